// ---- hw/corc_clock_output_routing_ctrl.sv ----
`timescale 1ns/100ps
//Contract
// R01 - control pin takes one of four functions
// R02 - select level picks one of two settings
// R03 - divider changes from select are glitch free
// R04 - suspend may ride along with frequency select
// R05 - enable mode: low floats all outputs
// R06 - shutdown low floats outputs, stops everything
// R07 - synthesizers relock after leaving shutdown
// R08 - lock completes within 3 ms, 1 typical
// R09 - suspended synthesizer never feeds active output
// R10 - suspend stops synth logic, floats outputs
// R11 - six-bit load capacitance, 0.375 pF steps
// R12 - oscillator drive strength is configurable
// R13 - driven reference bypasses caps, feedback floats
// R14 - crosspoint routes four sources to three outputs
// R15 - outputs A, B pick divider by select
// R16 - output C uses single divider setting
// R17 - inverted synth phase selectable per output
// R18 - synth rate is reference times P over Q; the model runs at reference times P over 16 Q
// R19 - divider value N divides by N
// R20 - control pin synchronized before use
module corc_clock_output_routing_ctrl
    import corc_pkg::*;
#(
    parameter int LOCK_CYC = LOCK_CYCLES_TYP
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire corc_cfg_t cfg_i,
    input wire logic freq_select_i,
    output logic clock_out_a_o,
    output logic clock_out_a_oe_o,
    output logic clock_out_b_o,
    output logic clock_out_b_oe_o,
    output logic clock_out_c_o,
    output logic clock_out_c_oe_o,
    output logic crystal_feedback_oe_o,
    output logic osc_run_o,
    output logic [CAP_W-1:0] cap_code_o,
    output logic [DRV_W-1:0] xtal_drive_o,
    output logic [NUM_SYNTH-1:0] synth_locked_o
);

    logic pin_s1_q, pin_s2_q;
    logic pin;
    logic shdn_act, oe_off, susp_act, fs_sel;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end
        else
        begin
            pin_s1_q <= freq_select_i; // R20
            pin_s2_q <= pin_s1_q; // R20
        end
    end

    always_comb
    begin
        pin = pin_s2_q;
        shdn_act = (cfg_i.pin_fn == CORC_FN_SHDN) && !pin; // R01 R06
        oe_off = (cfg_i.pin_fn == CORC_FN_OE) && !pin; // R05
        susp_act = ((cfg_i.pin_fn == CORC_FN_SUSP) || ((cfg_i.pin_fn == CORC_FN_FSEL) && cfg_i.fsel_susp)) && !pin; // R04
        fs_sel = (cfg_i.pin_fn == CORC_FN_FSEL) && pin; // R02
    end

    // reference as a source: a toggle that runs unless shut down
    logic ref_ph_q, ref_ph_d;
    always_comb
    begin
        ref_ph_d = shdn_act ? 1'b0 : !ref_ph_q; // R06
    end

    logic [NUM_SYNTH-1:0] ph_q, ph_d, syn_run, locked;
    logic [NUM_SYNTH-1:0][SYN_ACC_W-1:0] acc_q, acc_d;
    logic [NUM_SYNTH-1:0][LOCK_CNT_W-1:0] lk_q, lk_d;

    for (genvar k = 0; k < NUM_SYNTH; k++)
    begin : g_syn
        corc_synth_t set;
        logic [SYN_Q_W-1:0] q_eff;
        logic [SYN_ACC_W-1:0] thr;
        logic [SYN_ACC_W:0] sum;

        always_comb
        begin
            set = (k == 0 && fs_sel) ? cfg_i.synth_one_alt : cfg_i.synth[k]; // R02
            q_eff = (set.q == 8'h00) ? 8'h01 : set.q;
            thr = {q_eff, 4'h0};
            sum = {1'b0, acc_q[k]} + 13'(set.p);
            syn_run[k] = !shdn_act && !(susp_act && cfg_i.susp_synth[k]); // R06 R10
            locked[k] = (lk_q[k] == LOCK_CNT_W'(LOCK_CYC));
            acc_d[k] = acc_q[k];
            ph_d[k] = ph_q[k];
            lk_d[k] = lk_q[k];
            if (!syn_run[k])
            begin
                // stopped synth loses lock and must reacquire it
                acc_d[k] = '0;
                ph_d[k] = 1'b0;
                lk_d[k] = '0; // R07
            end
            else
            begin
                // at most one tick per cycle: the model tops out at the reference toggle rate
                if (sum >= {1'b0, thr})
                begin
                    acc_d[k] = SYN_ACC_W'(sum - {1'b0, thr}); // R18
                    ph_d[k] = !ph_q[k]; // R18
                end
                else
                begin
                    acc_d[k] = sum[SYN_ACC_W-1:0]; // R18
                end
                if (!locked[k])
                begin
                    lk_d[k] = lk_q[k] + 17'h0_0001; // R08
                end
            end
        end

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                acc_q[k] <= '0;
                ph_q[k] <= 1'b0;
                lk_q[k] <= '0;
            end
            else
            begin
                acc_q[k] <= acc_d[k];
                ph_q[k] <= ph_d[k];
                lk_q[k] <= lk_d[k];
            end
        end
    end

    logic [NUM_SYNTH:0] src_now, src_nxt, src_ok;
    always_comb
    begin
        src_now = {ph_q, ref_ph_q};
        src_nxt = {ph_d, ref_ph_d};
        // outputs only see a synth once it is locked and running
        src_ok = {locked & syn_run, !shdn_act}; // R07 R09
    end

    logic [NUM_OUT-1:0] oe_q, oe_d, clk_out;
    logic [NUM_OUT-1:0][DIV_W-1:0] div_sel;

    always_comb
    begin
        div_sel[OUT_A] = cfg_i.div_a[fs_sel]; // R15
        div_sel[OUT_B] = cfg_i.div_b[fs_sel]; // R15
        div_sel[OUT_C] = cfg_i.div_c; // R16
    end

    for (genvar x = 0; x < NUM_OUT; x++)
    begin : g_out
        logic [1:0] sel;
        logic lvl_now, lvl_nxt, run;

        always_comb
        begin
            sel = cfg_i.src_sel[x]; // R14
            lvl_now = src_now[sel] ^ cfg_i.invert[x]; // R17
            lvl_nxt = src_nxt[sel] ^ cfg_i.invert[x]; // R17
            oe_d[x] = !oe_off && !shdn_act && !(susp_act && cfg_i.susp_out[x]); // R05 R06 R10
            run = src_ok[sel] && !shdn_act && !(susp_act && cfg_i.susp_out[x]); // R10
        end

        corc_post_div u_div (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .run_i(run),
            .edge_i(lvl_nxt && !lvl_now),
            .lvl_i(lvl_nxt),
            .div_i(div_sel[x]),
            .clk_o(clk_out[x])
        );
    end

    logic [CAP_W-1:0] cap_q, cap_d;
    logic fb_oe_q, fb_oe_d, osc_q, osc_d;
    logic [DRV_W-1:0] drv_q, drv_d;
    logic [NUM_SYNTH-1:0] lock_out_q;

    always_comb
    begin
        cap_d = cfg_i.cap_bypass ? CAP_BYPASS_CODE : cfg_i.cap_load; // R11 R13
        drv_d = cfg_i.xtal_drive; // R12
        fb_oe_d = !cfg_i.cap_bypass && !shdn_act; // R13
        osc_d = !shdn_act; // R06
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_ph_q <= 1'b0;
            oe_q <= '0;
            cap_q <= '0;
            drv_q <= '0;
            fb_oe_q <= 1'b0;
            osc_q <= 1'b0;
            lock_out_q <= '0;
        end
        else
        begin
            ref_ph_q <= ref_ph_d;
            oe_q <= oe_d;
            cap_q <= cap_d;
            drv_q <= drv_d;
            fb_oe_q <= fb_oe_d;
            osc_q <= osc_d;
            lock_out_q <= locked;
        end
    end

    assign clock_out_a_o = clk_out[OUT_A];
    assign clock_out_b_o = clk_out[OUT_B];
    assign clock_out_c_o = clk_out[OUT_C];
    assign clock_out_a_oe_o = oe_q[OUT_A];
    assign clock_out_b_oe_o = oe_q[OUT_B];
    assign clock_out_c_oe_o = oe_q[OUT_C];
    assign cap_code_o = cap_q;
    assign xtal_drive_o = drv_q;
    assign crystal_feedback_oe_o = fb_oe_q;
    assign osc_run_o = osc_q;
    assign synth_locked_o = lock_out_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_SYNC_PIN: assert property (pin == $past(freq_select_i, 2)) // R20
        else $error("control pin not two-stage synchronized");
    AST_SHUT_HIZ: assert property (shdn_act |=> (oe_q == 3'h0 && !osc_q)) // R06
        else $error("shutdown did not float outputs and stop oscillator");
    AST_OE_HIZ: assert property (oe_off |=> oe_q == 3'h0) // R05
        else $error("enable low did not float outputs");
    AST_OE_DRIVE: assert property ((cfg_i.pin_fn == CORC_FN_OE && pin) |=> oe_q == 3'h7) // R05
        else $error("enable high did not drive outputs");
    AST_SUSP_OUT: assert property ((susp_act && cfg_i.susp_out[OUT_C]) |=> !oe_q[OUT_C]) // R10
        else $error("suspended output still driven");
    AST_SHUT_UNLOCK: assert property (shdn_act |=> ##1 synth_locked_o == 3'h0) // R07
        else $error("synth still locked after shutdown");
    AST_LOCK_TIME: assert property ($rose(locked[0]) |-> $past(lk_q[0]) == LOCK_CNT_W'(LOCK_CYC - 1)) // R08
        else $error("lock declared at wrong count");
    AST_CAP_BYPASS: assert property (cfg_i.cap_bypass |=> (cap_code_o == CAP_BYPASS_CODE && !crystal_feedback_oe_o)) // R13
        else $error("bypass did not clear caps and float feedback");
    AST_FS_SYNTH: assert property ((cfg_i.pin_fn == CORC_FN_FSEL && $rose(pin)) |-> (div_sel[OUT_A] == cfg_i.div_a[1] && div_sel[OUT_B] == cfg_i.div_b[1] && g_syn[0].set == cfg_i.synth_one_alt)) // R02
        else $error("frequency select did not follow pin");

    COV_SHUT_EXIT: cover property (shdn_act ##1 !shdn_act);
    COV_FS_TOGGLE: cover property (fs_sel ##1 !fs_sel && cfg_i.pin_fn == CORC_FN_FSEL);
    COV_SUSPEND: cover property (susp_act && cfg_i.susp_synth[1]);
    COV_LOCKED: cover property ($rose(synth_locked_o[0]));

endmodule // corc_clock_output_routing_ctrl

// ---- hw/corc_pkg.sv ----
package corc_pkg;

    // clock and timing
    localparam int CLK_PERIOD_PS = 25_000;
    localparam int LOCK_TIME_TYP_US = 1000;
    localparam int LOCK_TIME_MAX_US = 3000;
    // divide first: the full product for the maximum overflows a 32-bit int
    localparam int LOCK_CYCLES_TYP = LOCK_TIME_TYP_US * (1_000_000 / CLK_PERIOD_PS);
    localparam int LOCK_CYCLES_MAX = LOCK_TIME_MAX_US * (1_000_000 / CLK_PERIOD_PS);
    localparam int LOCK_CNT_W = 17;

    // synthesizer model: tick threshold is the predivider scaled by 2**SYN_SCALE_SH
    localparam int SYN_P_W = 11;
    localparam int SYN_Q_W = 8;
    localparam int SYN_SCALE_SH = 4;
    localparam int SYN_ACC_W = SYN_Q_W + SYN_SCALE_SH;
    localparam int NUM_SYNTH = 3;
    localparam int NUM_OUT = 3;

    localparam int DIV_W = 7;
    localparam int CAP_W = 6;
    localparam int DRV_W = 2;

    // crosspoint source codes
    localparam logic [1:0] SRC_REF = 2'h0;
    localparam logic [1:0] SRC_SYN_ONE = 2'h1;
    localparam logic [1:0] SRC_SYN_TWO = 2'h2;
    localparam logic [1:0] SRC_SYN_THREE = 2'h3;

    // output indices
    localparam int OUT_A = 0;
    localparam int OUT_B = 1;
    localparam int OUT_C = 2;

    localparam logic [CAP_W-1:0] CAP_BYPASS_CODE = 6'h00;

    typedef enum logic [1:0] {
        CORC_FN_FSEL,
        CORC_FN_SUSP,
        CORC_FN_OE,
        CORC_FN_SHDN
    } corc_pin_fn_t;

    typedef struct packed {
        logic [SYN_P_W-1:0] p;
        logic [SYN_Q_W-1:0] q;
    } corc_synth_t;

    typedef struct packed {
        corc_pin_fn_t pin_fn;
        logic fsel_susp;
        corc_synth_t [NUM_SYNTH-1:0] synth;
        corc_synth_t synth_one_alt;
        logic [NUM_OUT-1:0][1:0] src_sel;
        logic [NUM_OUT-1:0] invert;
        logic [1:0][DIV_W-1:0] div_a;
        logic [1:0][DIV_W-1:0] div_b;
        logic [DIV_W-1:0] div_c;
        logic [NUM_SYNTH-1:0] susp_synth;
        logic [NUM_OUT-1:0] susp_out;
        logic [CAP_W-1:0] cap_load;
        logic [DRV_W-1:0] xtal_drive;
        logic cap_bypass;
    } corc_cfg_t;

endpackage

// ---- hw/corc_post_div.sv ----
`timescale 1ns/100ps
module corc_post_div
    import corc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic edge_i,
    input wire logic lvl_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic clk_o
);

    logic [DIV_W-1:0] cnt_q, cnt_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic out_q, out_d;
    logic wrap;
    logic [DIV_W:0] half;

    always_comb
    begin
        cnt_d = cnt_q;
        div_d = div_q;
        out_d = 1'b0;
        wrap = ({1'b0, cnt_q} + 8'h01) >= {1'b0, div_q};
        half = ({1'b0, div_q} + 8'h01) >> 1;
        if (!run_i)
        begin
            cnt_d = '0;
            div_d = div_i;
        end
        else
        begin
            if (edge_i)
            begin
                // new value only taken at a period boundary: no runt pulses
                if (wrap)
                begin
                    cnt_d = '0;
                    div_d = div_i; // R03
                end
                else
                begin
                    cnt_d = cnt_q + 7'h01; // R19
                end
            end
            if (div_q == 7'h01)
            begin
                out_d = lvl_i; // R19
            end
            else
            begin
                // zero holds the output low
                out_d = (div_q != 7'h00) && ({1'b0, cnt_d} < half); // R19
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= '0;
            div_q <= '0;
            out_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            div_q <= div_d;
            out_q <= out_d;
        end
    end

    assign clk_o = out_q;

    AST_DIV_BOUNDARY: assert property (@(posedge clk_i) disable iff (rst_i) // R03
        (run_i && $past(run_i) && $changed(div_q)) |-> $past(edge_i && wrap))
        else $error("divider value changed inside a period");

endmodule // corc_post_div

// ---- sim/corc_load_model.sv ----
`timescale 1ns/100ps
module corc_load_model
(
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic oe_i,
    input wire logic clr_i,
    output int period_o,
    output int min_period_o
);
    // a floating pad reads as z, so no edge is counted while it is off
    wire pad = oe_i ? pin_i : 1'bz;
    logic last_q = 1'b0;
    logic seen_q = 1'b0;
    int cnt_q = 0;
    int rise_q = 0;
    initial period_o = 0;
    initial min_period_o = 999;
    always @(posedge clk_i)
    begin
        cnt_q <= cnt_q + 1;
        last_q <= pad;
        if (clr_i)
        begin
            seen_q <= 1'b0;
            min_period_o <= 999;
        end
        else if (pad === 1'b1 && last_q === 1'b0)
        begin
            rise_q <= cnt_q;
            seen_q <= 1'b1;
            if (seen_q)
            begin
                period_o <= cnt_q - rise_q;
                if (cnt_q - rise_q < min_period_o)
                    min_period_o <= cnt_q - rise_q;
            end
        end
    end
endmodule // corc_load_model

// ---- sim/clock_output_routing_ctrl_tb_top.sv ----
`timescale 1ns/100ps
module clock_output_routing_ctrl_tb_top;
    import corc_pkg::*;
    localparam int LCYC = 20;
    typedef struct {
        corc_pin_fn_t fn;
        logic fs_susp;
        logic pin;
        logic [2:0] susp_out;
        logic [2:0] oe;
        logic run;
    } corc_tb_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fsel = 1'b1;
    logic clr = 1'b0;
    corc_cfg_t cfg = '0;
    logic [2:0] ck, oe, locked;
    logic fb_oe, run;
    logic [CAP_W-1:0] cap;
    logic [DRV_W-1:0] drv;
    int per [3];
    int minp [3];
    int error_cnt = 0;
    int comparisons = 0;
    corc_tb_row_t rows [9] = '{
        '{CORC_FN_FSEL, 1'b0, 1'b0, 3'h7, 3'h7, 1'b1},
        '{CORC_FN_FSEL, 1'b1, 1'b0, 3'h5, 3'h2, 1'b1},
        '{CORC_FN_FSEL, 1'b1, 1'b1, 3'h5, 3'h7, 1'b1},
        '{CORC_FN_SUSP, 1'b0, 1'b0, 3'h3, 3'h4, 1'b1},
        '{CORC_FN_SUSP, 1'b0, 1'b1, 3'h3, 3'h7, 1'b1},
        '{CORC_FN_OE, 1'b0, 1'b0, 3'h0, 3'h0, 1'b1},
        '{CORC_FN_OE, 1'b0, 1'b1, 3'h0, 3'h7, 1'b1},
        '{CORC_FN_SHDN, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0},
        '{CORC_FN_SHDN, 1'b0, 1'b1, 3'h0, 3'h7, 1'b1}
    };

    always #12.5 clk_i = ~clk_i;

    corc_clock_output_routing_ctrl #(.LOCK_CYC(LCYC)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .freq_select_i(fsel),
        .clock_out_a_o(ck[0]), .clock_out_a_oe_o(oe[0]), .clock_out_b_o(ck[1]), .clock_out_b_oe_o(oe[1]),
        .clock_out_c_o(ck[2]), .clock_out_c_oe_o(oe[2]), .crystal_feedback_oe_o(fb_oe), .osc_run_o(run),
        .cap_code_o(cap), .xtal_drive_o(drv), .synth_locked_o(locked));

    for (genvar g = 0; g < 3; g++)
    begin : g_load
        corc_load_model u_load (.clk_i(clk_i), .pin_i(ck[g]), .oe_i(oe[g]), .clr_i(clr),
            .period_o(per[g]), .min_period_o(minp[g]));
    end

    task automatic cmp_bits(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_cyc(input string name, input int exp, input int got);
        comparisons++;
        if (got != exp)
        begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // period figures only count rises seen after the clear
    task automatic clear_load();
        clr = 1'b1;
        wt(1);
        clr = 1'b0;
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end

    initial
    begin
        for (int i = 0; i < 3; i++)
        begin
            cfg.synth[i].p = 11'h008;
            cfg.synth[i].q = 8'h01;
        end
        cfg.synth_one_alt.p = 11'h010;
        cfg.synth_one_alt.q = 8'h01;
        cfg.div_a[0] = 7'h03;
        cfg.div_a[1] = 7'h05;
        cfg.div_b[0] = 7'h01;
        cfg.div_b[1] = 7'h02;
        cfg.div_c = 7'h04;
        cfg.cap_load = 6'h2A;
        cfg.xtal_drive = 2'h2;
        wt(2);
        rst_i = 1'b0;
        foreach (rows[i])
        begin
            cfg.pin_fn = rows[i].fn;
            cfg.fsel_susp = rows[i].fs_susp;
            cfg.susp_out = rows[i].susp_out;
            fsel = rows[i].pin;
            wt(5);
            cmp_bits("oe", 8'(rows[i].oe), 8'(oe));
            cmp_bits("osc_run", 8'(rows[i].run), 8'(run));
            cmp_bits("fb_oe", 8'(rows[i].run), 8'(fb_oe));
        end
        cmp_bits("cap", 8'h2A, 8'(cap));
        cmp_bits("drive", 8'h02, 8'(drv));
        cfg.cap_bypass = 1'b1;
        wt(2);
        cmp_bits("cap_byp", 8'h00, 8'(cap));
        cmp_bits("fb_byp", 8'h00, 8'(fb_oe));
        cfg.cap_bypass = 1'b0;
        cfg.pin_fn = CORC_FN_FSEL;
        fsel = 1'b0;
        wt(40);
        cmp_cyc("per_a0", 6, per[0]);
        cmp_cyc("per_b0", 2, per[1]);
        cmp_cyc("per_c0", 8, per[2]);
        clear_load();
        wt(20);
        fsel = 1'b1;
        wt(60);
        cmp_cyc("per_a1", 10, per[0]);
        cmp_cyc("per_b1", 4, per[1]);
        cmp_cyc("per_c1", 8, per[2]);
        cmp_cyc("min_a", 6, minp[0]);
        cmp_cyc("min_b", 2, minp[1]);
        cmp_cyc("min_c", 8, minp[2]);
        // pin path is two flops plus the enable register
        cfg.pin_fn = CORC_FN_OE;
        wt(4);
        fsel = 1'b0;
        wt(2);
        cmp_bits("oe_sync", 8'h07, 8'(oe));
        wt(1);
        cmp_bits("oe_low", 8'h00, 8'(oe));
        fsel = 1'b1;
        cfg.pin_fn = CORC_FN_FSEL;
        cfg.src_sel[OUT_A] = SRC_SYN_TWO;
        wt(10);
        clear_load();
        wt(80);
        cmp_cyc("per_syn", 20, per[0]);
        // B shares synth two with A in the opposite phase; C follows synth one
        cfg.div_a[1] = 7'h01;
        cfg.div_b[1] = 7'h01;
        cfg.src_sel[OUT_B] = SRC_SYN_TWO;
        cfg.src_sel[OUT_C] = SRC_SYN_ONE;
        cfg.invert[OUT_B] = 1'b1;
        wt(30);
        clear_load();
        wt(40);
        cmp_bits("inv_ab", 8'h01, 8'(ck[0] ^ ck[1]));
        cmp_cyc("per_inv", 4, per[1]);
        cmp_cyc("per_fs_hi", 8, per[2]);
        fsel = 1'b0;
        wt(60);
        cmp_cyc("per_fs_lo", 16, per[2]);
        cfg.pin_fn = CORC_FN_SHDN;
        fsel = 1'b0;
        wt(5);
        cmp_bits("lock_sd", 8'h00, 8'(locked));
        fsel = 1'b1;
        wt(4);
        cmp_bits("lock_early", 8'h00, 8'(locked));
        wt(LCYC + 4);
        cmp_bits("lock_back", 8'h07, 8'(locked));
        // output A rides on synth two, so both go down together
        cfg.pin_fn = CORC_FN_SUSP;
        cfg.susp_synth = 3'h2;
        cfg.susp_out = 3'h1;
        fsel = 1'b0;
        wt(5);
        cmp_bits("lock_susp", 8'h05, 8'(locked));
        cmp_bits("oe_susp", 8'h06, 8'(oe));
        cmp_bits("clk_a_susp", 8'h00, 8'(ck[0]));
        fsel = 1'b1;
        wt(LCYC + 6);
        cmp_bits("lock_res", 8'h07, 8'(locked));
        // mid-run reset: everything drops, lock count restarts from zero
        rst_i = 1'b1;
        wt(2);
        cmp_bits("rst_out", 8'h00, 8'({oe, ck, run, fb_oe}));
        cmp_bits("rst_lock", 8'h00, 8'(locked));
        rst_i = 1'b0;
        wt(2);
        cmp_bits("rst_oe", 8'h07, 8'(oe));
        cmp_bits("rst_lock_early", 8'h00, 8'(locked));
        wt(LCYC + 2);
        cmp_bits("rst_lock_back", 8'h07, 8'(locked));
        complete_run();
    end
endmodule // clock_output_routing_ctrl_tb_top
